// ==== hdl/obd_cfg_map.vh ====
/*
 constants for the configuration command handler: register offsets,
 command codes, protocol numbers, field positions and divider figures.
 assumes inclusion by bare name from the handler source.
*/
// How it works
// - calibrate: recompute scale so input reads value
// - all-zero argument restores factory scale
// - factory divider 1:5.7 above 4v, else 1:11
// - defaults reload stored protocol, closing active one
// - defaults restore headers, filters, masks, timers
// - length digit shown per option, default from parameter
// - trouble-code monitor watches broadcasts, reassembles segments
// - monitor refused unless protocol a, b or c
// - describe gives protocol name, auto flagged
// - numeric describe gives number, prefixed a if auto
// - echo received characters while enabled, default on
// - flow data one to five bytes, filler padded
// - 11-bit flow id keeps low 11 bits
// - 29-bit flow id keeps low 29 bits
// - flow mode 0 auto, 1 user, 2 data
// - mode 1 or 2 refused without needed data
// - fatal can error blocks searches if bit 5
// - low-voltage reset blocks searches if bit 4
// - forget events clears both latched events
// - fast init only under protocol 5, else error
// - protocol change closes active protocol first
// - auto flow frame answers each first frame
`ifndef OBD_CFG_MAP_VH
`define OBD_CFG_MAP_VH

// register byte offsets
`define OFS_CMD 8'h00
`define OFS_ARG0 8'h04
`define OFS_ARG1 8'h08
`define OFS_STATUS 8'h0c
`define OFS_SCALE 8'h10
`define OFS_PROTO 8'h14
`define OFS_PARAM 8'h18
`define OFS_DESCR 8'h1c
`define OFS_FC_HDR 8'h20
`define OFS_FC_DATA 8'h24
`define OFS_VOLT 8'h28

// command codes
`define CMD_CAL 4'h1
`define CMD_DEFAULTS 4'h2
`define CMD_LEN_HIDE 4'h3
`define CMD_LEN_SHOW 4'h4
`define CMD_DM1 4'h5
`define CMD_ECHO_OFF 4'h6
`define CMD_ECHO_ON 4'h7
`define CMD_FC_DATA 4'h8
`define CMD_FC_HDR 4'h9
`define CMD_FC_MODE 4'ha
`define CMD_FORGET 4'hb
`define CMD_FAST_INIT 4'hc
`define CMD_AUTO_FC_OFF 4'hd
`define CMD_AUTO_FC_ON 4'he

// protocol numbers
`define PROTO_KWP_FAST 4'h5
`define PROTO_J1939_LO 4'ha
`define PROTO_J1939_HI 4'hc

// parameter bits and the arg1 long-id bit
`define BIT_BLOCK_FATAL 5
`define BIT_BLOCK_LV 4
`define BIT_LEN_DEFAULT 0
`define BIT_ARG1_LONG_ID 8

// flow control
`define FC_MODE_AUTO 2'h0
`define FC_MODE_USER 2'h1
`define FC_MODE_DATA 2'h2
`define FC_MAX_BYTES 3'h5
`define ID11_MASK 32'h000007ff
`define ID29_MASK 32'h1fffffff

// scale arithmetic: reading = sample * scale >> SCALE_SHIFT
`define SCALE_SHIFT 12
`define DIV_STEPS 5'd26
`define ASCII_A 8'h41
`define ASCII_0 8'h30
`define ASCII_UPPER 8'h37

`endif

// ==== hdl/obd_config_command_handler.v ====
/*
 configuration command handler: executes host commands written over a
 plain register port, keeps calibration, echo, length digit, flow control
 and event latches, and drives pulses toward the protocol engines.
 assumes the serial framing and text parser sit outside and hand over
 decoded commands; event, sample and first-frame inputs share core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "obd_cfg_map.vh"

module obd_config_command_handler #(
    parameter [15:0] FACTORY_SCALE_HIGH = 16'h0b66,
    parameter [15:0] FACTORY_SCALE_LOW = 16'h1600,
    parameter [7:0] CAN_FILLER = 8'h00,
    parameter [3:0] POWER_UP_PROTOCOL = 4'h0
) (
    input wire core_clk,
    input wire arst_n,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    output reg [31:0] rdata,
    input wire rx_valid,
    input wire [7:0] rx_char,
    output reg echo_valid,
    output reg [7:0] echo_char,
    input wire [9:0] volt_sample,
    input wire supply_above_4v,
    input wire [3:0] stored_protocol,
    input wire fatal_can_error_event,
    input wire low_voltage_reset_event,
    input wire first_frame_rx,
    output reg flow_ctrl_send,
    output reg close_protocol,
    output reg restore_defaults,
    output reg fast_init_start,
    output reg dm1_monitor,
    output reg length_digit_show,
    output reg can_search_blocked,
    output reg [1:0] fc_mode,
    output reg [28:0] fc_header,
    output reg fc_header_long,
    output reg [39:0] fc_data,
    output reg [13:0] volt_reading
);

    localparam ST_IDLE = 1'b0;
    localparam ST_DIV = 1'b1;

    reg state;
    reg [31:0] arg0;
    reg [31:0] arg1;
    reg [15:0] scale;
    reg user_cal;
    reg [3:0] protocol;
    reg auto_search;
    reg [15:0] param;
    reg echo_on;
    reg auto_fc;
    reg fc_data_defined;
    reg fc_hdr_defined;
    reg fatal_seen;
    reg lv_seen;
    reg cmd_error;
    reg cmd_done;
    reg [4:0] div_count;
    reg [25:0] div_quot;
    reg [10:0] div_rem;
    reg [9:0] div_sample;
    reg sup_s1;
    reg sup_s2;
    reg sup_s3;
    reg supply_high;
    wire [39:0] next_fc_data;
    wire [39:0] fc_src = {arg1[15:8], arg0};
    wire [31:0] id_short = arg0 & `ID11_MASK;
    wire [31:0] id_long = arg0 & `ID29_MASK;
    reg [31:0] next_rdata;
    wire [13:0] cal_value;
    wire [25:0] cal_shifted;
    wire [25:0] product;
    wire [15:0] factory_scale;
    wire [10:0] rem_shift;
    wire cmd_wr;
    wire [3:0] cmd_code;
    wire [2:0] fc_count;
    wire j1939_sel;
    genvar gi;

    // bcd digits to centivolts, point between second and third digit
    assign cal_value = arg0[15:12] * 14'd1000 + arg0[11:8] * 14'd100
        + arg0[7:4] * 14'd10 + {10'h000, arg0[3:0]};
    assign cal_shifted = {cal_value, 12'h000};
    assign product = volt_sample * scale;
    assign factory_scale = supply_high ? FACTORY_SCALE_HIGH : FACTORY_SCALE_LOW;
    assign rem_shift = {div_rem[9:0], div_quot[25]};
    assign cmd_wr = wr_stb && (addr == `OFS_CMD);
    assign cmd_code = wdata[3:0];
    assign fc_count = arg1[2:0];
    assign j1939_sel = (protocol >= `PROTO_J1939_LO) && (protocol <= `PROTO_J1939_HI);

    // supply level pin, three-stage filter
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sup_s1 <= 1'b1;
            sup_s2 <= 1'b1;
            sup_s3 <= 1'b1;
            supply_high <= 1'b1;
        end
        else
        begin
            sup_s1 <= supply_above_4v;
            sup_s2 <= sup_s1;
            sup_s3 <= sup_s2;
            if (sup_s2 == sup_s3)
                supply_high <= sup_s3;
        end
    end

    // flow data: given bytes kept, remainder padded
    generate
        for (gi = 0; gi < 5; gi = gi + 1)
        begin : g_fc_byte
            assign next_fc_data[gi*8 +: 8] = (gi < fc_count) ? fc_src[gi*8 +: 8]
                : CAN_FILLER;
        end
    endgenerate

    // read mux
    always @*
    begin
        case (addr)
            `OFS_ARG0: next_rdata = arg0;
            `OFS_ARG1: next_rdata = arg1;
            `OFS_STATUS: next_rdata = {16'h0000, state, protocol[3:0], auto_search,
                can_search_blocked, lv_seen, fatal_seen, dm1_monitor, fc_mode,
                length_digit_show, echo_on, cmd_done, cmd_error};
            `OFS_SCALE: next_rdata = {15'h0000, user_cal, scale};
            `OFS_PROTO: next_rdata = {27'h0000000, auto_search, protocol};
            `OFS_PARAM: next_rdata = {16'h0000, param};
            // name index with auto flag; ascii number, 'A' prefix when auto
            `OFS_DESCR: next_rdata = {7'h00, auto_search, 4'h0, protocol,
                (auto_search ? `ASCII_A : 8'h00),
                ((protocol > 4'h9) ? (`ASCII_UPPER + {4'h0, protocol})
                : (`ASCII_0 + {4'h0, protocol}))};
            `OFS_FC_HDR: next_rdata = {fc_hdr_defined, fc_header_long, 1'b0, fc_header};
            `OFS_FC_DATA: next_rdata = fc_data[31:0];
            `OFS_VOLT: next_rdata = {18'h00000, volt_reading};
            default: next_rdata = 32'h00000000;
        endcase
    end

    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata <= 32'h00000000;
            echo_valid <= 1'b0;
            echo_char <= 8'h00;
            volt_reading <= 14'h0000;
            flow_ctrl_send <= 1'b0;
        end
        else
        begin
            if (rd_stb)
                rdata <= next_rdata;
            else
                rdata <= 32'h00000000;
            echo_valid <= rx_valid && echo_on;
            echo_char <= rx_char;
            volt_reading <= product[25:12];
            flow_ctrl_send <= first_frame_rx && auto_fc;
        end
    end

    // command execution
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= ST_IDLE;
            arg0 <= 32'h00000000;
            arg1 <= 32'h00000000;
            scale <= 16'h0000;
            user_cal <= 1'b0;
            protocol <= POWER_UP_PROTOCOL;
            auto_search <= 1'b1;
            param <= 16'h0000;
            echo_on <= 1'b1;
            auto_fc <= 1'b1;
            fc_data_defined <= 1'b0;
            fc_hdr_defined <= 1'b0;
            fatal_seen <= 1'b0;
            lv_seen <= 1'b0;
            cmd_error <= 1'b0;
            cmd_done <= 1'b0;
            div_count <= 5'd0;
            div_quot <= 26'h0000000;
            div_rem <= 11'h000;
            div_sample <= 10'h000;
            close_protocol <= 1'b0;
            restore_defaults <= 1'b0;
            fast_init_start <= 1'b0;
            dm1_monitor <= 1'b0;
            length_digit_show <= 1'b0;
            can_search_blocked <= 1'b0;
            fc_mode <= `FC_MODE_AUTO;
            fc_header <= 29'h00000000;
            fc_header_long <= 1'b0;
            fc_data <= 40'h0000000000;
        end
        else
        begin
            close_protocol <= 1'b0;
            restore_defaults <= 1'b0;
            fast_init_start <= 1'b0;
            if (!user_cal)
                scale <= factory_scale;
            can_search_blocked <= (fatal_seen && param[`BIT_BLOCK_FATAL])
                || (lv_seen && param[`BIT_BLOCK_LV]);
            if (wr_stb && addr == `OFS_ARG0)
                arg0 <= wdata;
            if (wr_stb && addr == `OFS_ARG1)
                arg1 <= wdata;
            if (wr_stb && addr == `OFS_PARAM)
                param <= wdata[15:0];
            if (wr_stb && addr == `OFS_PROTO)
            begin
                protocol <= wdata[3:0];
                auto_search <= wdata[4];
                close_protocol <= 1'b1;
                dm1_monitor <= 1'b0;
            end
            if (state == ST_DIV)
            begin
                // restoring divide of centivolts by sample
                if (rem_shift >= {1'b0, div_sample})
                begin
                    div_rem <= rem_shift - {1'b0, div_sample};
                    div_quot <= {div_quot[24:0], 1'b1};
                end
                else
                begin
                    div_rem <= rem_shift;
                    div_quot <= {div_quot[24:0], 1'b0};
                end
                div_count <= div_count - 5'd1;
                if (div_count == 5'd1)
                begin
                    state <= ST_IDLE;
                    cmd_done <= 1'b1;
                    user_cal <= 1'b1;
                    if (div_quot[24:15] != 10'h000)
                        scale <= 16'hffff;
                    else
                        scale <= {div_quot[14:0], rem_shift >= {1'b0, div_sample}};
                end
            end
            if (cmd_wr)
            begin
                cmd_done <= 1'b1;
                cmd_error <= 1'b0;
                if (state == ST_DIV)
                    cmd_error <= 1'b1;
                else
                begin
                    case (cmd_code)
                        `CMD_CAL:
                        begin
                            if (arg0[15:0] == 16'h0000)
                                user_cal <= 1'b0;
                            else if (arg0[15:12] > 4'h9 || arg0[11:8] > 4'h9
                                || arg0[7:4] > 4'h9 || arg0[3:0] > 4'h9
                                || volt_sample == 10'h000)
                                cmd_error <= 1'b1;
                            else
                            begin
                                state <= ST_DIV;
                                cmd_done <= 1'b0;
                                div_count <= `DIV_STEPS;
                                div_quot <= cal_shifted;
                                div_rem <= 11'h000;
                                div_sample <= volt_sample;
                            end
                        end
                        `CMD_DEFAULTS:
                        begin
                            protocol <= stored_protocol;
                            close_protocol <= 1'b1;
                            restore_defaults <= 1'b1;
                            echo_on <= 1'b1;
                            auto_fc <= 1'b1;
                            dm1_monitor <= 1'b0;
                            fc_mode <= `FC_MODE_AUTO;
                            fc_data_defined <= 1'b0;
                            fc_hdr_defined <= 1'b0;
                            length_digit_show <= param[`BIT_LEN_DEFAULT];
                        end
                        `CMD_LEN_HIDE: length_digit_show <= 1'b0;
                        `CMD_LEN_SHOW: length_digit_show <= 1'b1;
                        `CMD_DM1:
                        begin
                            if (j1939_sel)
                                dm1_monitor <= 1'b1;
                            else
                                cmd_error <= 1'b1;
                        end
                        `CMD_ECHO_OFF: echo_on <= 1'b0;
                        `CMD_ECHO_ON: echo_on <= 1'b1;
                        `CMD_FC_DATA:
                        begin
                            if (fc_count == 3'h0 || fc_count > `FC_MAX_BYTES)
                                cmd_error <= 1'b1;
                            else
                            begin
                                fc_data <= next_fc_data;
                                fc_data_defined <= 1'b1;
                            end
                        end
                        `CMD_FC_HDR:
                        begin
                            fc_hdr_defined <= 1'b1;
                            fc_header_long <= arg1[`BIT_ARG1_LONG_ID];
                            if (arg1[`BIT_ARG1_LONG_ID])
                                fc_header <= id_long[28:0];
                            else
                                fc_header <= id_short[28:0];
                        end
                        `CMD_FC_MODE:
                        begin
                            if (arg0[31:2] != 30'h00000000 || arg0[1:0] == 2'h3)
                                cmd_error <= 1'b1;
                            else if ((arg0[1:0] == `FC_MODE_USER
                                && !(fc_data_defined && fc_hdr_defined))
                                || (arg0[1:0] == `FC_MODE_DATA && !fc_data_defined))
                                cmd_error <= 1'b1;
                            else
                                fc_mode <= arg0[1:0];
                        end
                        `CMD_FAST_INIT:
                        begin
                            if (protocol == `PROTO_KWP_FAST)
                                fast_init_start <= 1'b1;
                            else
                                cmd_error <= 1'b1;
                        end
                        `CMD_AUTO_FC_OFF: auto_fc <= 1'b0;
                        `CMD_AUTO_FC_ON: auto_fc <= 1'b1;
                        `CMD_FORGET: ;
                        default: cmd_error <= 1'b1;
                    endcase
                end
            end
            // events latch; a new event beats a same-cycle forget
            if (cmd_wr && cmd_code == `CMD_FORGET && state == ST_IDLE)
            begin
                fatal_seen <= 1'b0;
                lv_seen <= 1'b0;
            end
            if (fatal_can_error_event)
                fatal_seen <= 1'b1;
            if (low_voltage_reset_event)
                lv_seen <= 1'b1;
        end
    end

endmodule // obd_config_command_handler

`default_nettype wire

// ==== sim/obd_cfg_props.sv ====
/* port checker for the config command handler.
 assumes a bind onto the handler, one clock core_clk. */
`timescale 1ns/10ps
`default_nettype none
`include "obd_cfg_map.vh"

module obd_cfg_props (
    input wire core_clk,
    input wire arst_n,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr_stb,
    input wire rx_valid,
    input wire echo_valid,
    input wire fatal_can_error_event,
    input wire low_voltage_reset_event,
    input wire first_frame_rx,
    input wire flow_ctrl_send,
    input wire close_protocol,
    input wire fast_init_start,
    input wire dm1_monitor,
    input wire can_search_blocked,
    input wire [1:0] fc_mode,
    input wire [28:0] fc_header,
    input wire fc_header_long
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    wire cmd_wr = wr_stb && addr == `OFS_CMD;
    wire cause = fatal_can_error_event | low_voltage_reset_event | (wr_stb && addr == `OFS_PARAM);
    chk_echo_cause: assert property (echo_valid |-> $past(rx_valid))
        else $error("echo without a received char");
    chk_flow_cause: assert property (flow_ctrl_send |-> $past(first_frame_rx))
        else $error("flow frame without first frame");
    chk_fast_gate: assert property (fast_init_start |->
        $past(cmd_wr && wdata[3:0] == `CMD_FAST_INIT))
        else $error("fast init without command");
    chk_proto_close: assert property (wr_stb && addr == `OFS_PROTO |=> close_protocol)
        else $error("protocol change did not close");
    chk_defaults_close: assert property (cmd_wr && wdata[3:0] == `CMD_DEFAULTS
        |=> close_protocol ##1 !close_protocol)
        else $error("defaults close pulse wrong");
    chk_mode_legal: assert property (fc_mode != 2'h3)
        else $error("illegal flow mode");
    chk_id_short: assert property (!fc_header_long |-> fc_header[28:11] == 18'h0)
        else $error("short id kept high bits");
    chk_dm1_gate: assert property ($rose(dm1_monitor) |->
        $past(cmd_wr && wdata[3:0] == `CMD_DM1))
        else $error("monitor began without command");
    chk_block_cause: assert property ($rose(can_search_blocked) |->
        $past(cause, 1) || $past(cause, 2) || $past(cause, 3))
        else $error("search block without cause");
    cover property (fast_init_start);
    cover property ($rose(can_search_blocked));
    cover property (flow_ctrl_send);
endmodule // obd_cfg_props

`default_nettype wire

// ==== sim/host_serial_model.sv ====
/* host side model: hands serial characters to the handler.
 assumes calls to send from the bench main thread. */
`timescale 1ns/10ps
`default_nettype none

module host_serial_model (
    input wire core_clk,
    output logic rx_valid,
    output logic [7:0] rx_char
);
    initial
    begin
        rx_valid = 1'b0;
        rx_char = 8'h00;
    end
    // one char per call; line then shows the inverse
    task automatic send(input logic [7:0] ch);
        @(posedge core_clk);
        rx_valid <= 1'b1;
        rx_char <= ch;
        @(posedge core_clk);
        rx_valid <= 1'b0;
        rx_char <= ~ch;
    endtask
endmodule // host_serial_model

`default_nettype wire

// ==== sim/obd_config_command_handler_bench.sv ====
/* self-checking bench for the config command handler.
 assumes checker and host model compiled first. */
`timescale 1ns/10ps
`default_nettype none
`include "obd_cfg_map.vh"

module obd_config_command_handler_bench;
    localparam logic [7:0] filler = 8'haa;
    localparam logic [15:0] fhi = 16'h0b66, flo = 16'h1600;
    logic core_clk = 0, arst_n = 0, wr_stb = 0, rd_stb = 0, supply_above_4v = 1;
    logic fatal_can_error_event = 0, low_voltage_reset_event = 0, first_frame_rx = 0;
    logic [7:0] addr = 8'h00, c;
    logic [31:0] wdata = 32'h0, v, d;
    logic [9:0] volt_sample = 10'h200;
    logic [3:0] stored_protocol = 4'h0;
    wire rx_valid, echo_valid, flow_ctrl_send, close_protocol, restore_defaults, fast_init_start;
    wire dm1_monitor, length_digit_show, can_search_blocked, fc_header_long;
    wire [7:0] rx_char, echo_char;
    wire [31:0] rdata;
    wire [1:0] fc_mode;
    wire [28:0] fc_header;
    wire [39:0] fc_data;
    wire [13:0] volt_reading;
    int n_mismatch = 0, compares = 0, i;
    obd_config_command_handler #(.FACTORY_SCALE_HIGH(fhi), .FACTORY_SCALE_LOW(flo),
        .CAN_FILLER(filler)) DUT (.core_clk(core_clk), .arst_n(arst_n), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .rx_valid(rx_valid),
        .rx_char(rx_char), .echo_valid(echo_valid), .echo_char(echo_char),
        .volt_sample(volt_sample), .supply_above_4v(supply_above_4v),
        .stored_protocol(stored_protocol), .fatal_can_error_event(fatal_can_error_event),
        .low_voltage_reset_event(low_voltage_reset_event), .first_frame_rx(first_frame_rx),
        .flow_ctrl_send(flow_ctrl_send), .close_protocol(close_protocol),
        .restore_defaults(restore_defaults), .fast_init_start(fast_init_start),
        .dm1_monitor(dm1_monitor), .length_digit_show(length_digit_show),
        .can_search_blocked(can_search_blocked), .fc_mode(fc_mode), .fc_header(fc_header),
        .fc_header_long(fc_header_long), .fc_data(fc_data), .volt_reading(volt_reading));
    host_serial_model host (.core_clk(core_clk), .rx_valid(rx_valid), .rx_char(rx_char));
    always #4 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] q);
        @(posedge core_clk);
        addr <= a;
        wdata <= q;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        @(posedge core_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        #1;
        q = rdata;
    endtask
    task automatic cmd(input logic [3:0] k, input logic [31:0] a0, input logic [31:0] a1);
        wr(`OFS_ARG0, a0);
        wr(`OFS_ARG1, a1);
        wr(`OFS_CMD, {28'h0, k});
        #1;
    endtask
    task automatic cmdr(input logic [3:0] k, input logic [31:0] a0, a1, input logic e);
        cmd(k, a0, a1);
        rd(`OFS_STATUS, v);
        chk(v[0], e, "error flag");
    endtask
    task automatic ev(input logic f, input logic l);
        @(posedge core_clk);
        fatal_can_error_event <= f;
        low_voltage_reset_event <= l;
        @(posedge core_clk);
        fatal_can_error_event <= 1'b0;
        low_voltage_reset_event <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic cal(input logic [15:0] bcd);
        cmd(`CMD_CAL, bcd, 0);
        v = 32'h8000;
        for (int j = 0; j < 40 && v[15] !== 1'b0; j++) rd(`OFS_STATUS, v);
        rd(`OFS_SCALE, v);
    endtask
    function automatic logic [15:0] scale_of(input logic [9:0] sm, input logic [15:0] bcd);
        int cv;
        cv = bcd[15:12] * 1000 + bcd[11:8] * 100 + bcd[7:4] * 10 + bcd[3:0];
        cv = (cv << 12) / sm;
        scale_of = (cv > 32'hffff) ? 16'hffff : cv[15:0];
    endfunction
    function automatic logic [31:0] descr_exp(input logic [3:0] pr, input logic au);
        descr_exp = {7'h0, au, 4'h0, pr, au ? `ASCII_A : 8'h00,
            (pr < 10) ? `ASCII_0 + pr : `ASCII_UPPER + pr};
    endfunction
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        $display("ERROR %0t watchdog expired", $time);
        wrap_up;
    end
    initial
    begin
        d = $urandom(32'hcb79d608);
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(`OFS_STATUS, v);
        chk(v, 32'h0000_0404, "status after reset");
        rd(8'hfc, v);
        chk(v, 32'h0, "unmapped read");
        $display("test reset done");
        for (i = 0; i < 3; i++)
        begin
            if (i > 0) cmd(i == 1 ? `CMD_ECHO_OFF : `CMD_ECHO_ON, 0, 0);
            if (i > 0) cmd(i == 1 ? `CMD_AUTO_FC_OFF : `CMD_AUTO_FC_ON, 0, 0);
            if (i > 0) cmd(i == 1 ? `CMD_LEN_SHOW : `CMD_LEN_HIDE, 0, 0);
            chk(length_digit_show, i == 1, "length digit");
            c = 8'($urandom);
            host.send(c);
            #1;
            chk(echo_valid, i != 1, "echo pulse");
            if (i != 1) chk(echo_char, c, "echo char");
            @(posedge core_clk);
            first_frame_rx <= 1'b1;
            @(posedge core_clk);
            first_frame_rx <= 1'b0;
            #1;
            chk(flow_ctrl_send, i != 1, "flow reply");
        end
        $display("test echo and flow reply done");
        for (i = 0; i < 13; i++)
        begin
            wr(`OFS_PROTO, {27'h0, i[0], i[3:0]});
            #1;
            chk(close_protocol, 1, "close on change");
            rd(`OFS_DESCR, v);
            chk(v, descr_exp(i[3:0], i[0]), "describe");
            cmd(`CMD_FAST_INIT, 0, 0);
            chk(fast_init_start, i == 5, "fast init");
            cmdr(`CMD_DM1, 0, 0, i < 10);
            if (i >= 10) chk(dm1_monitor, 1, "monitor on");
        end
        $display("test protocols done");
        d = $urandom;
        cmdr(`CMD_FC_MODE, 1, 0, 1);
        cmdr(`CMD_FC_MODE, 2, 0, 1);
        cmdr(`CMD_FC_DATA, d, 6, 1);
        cmdr(`CMD_FC_DATA, d, 3, 0);
        chk(fc_data[39:8], {filler, filler, d[23:8]}, "data padded");
        cmdr(`CMD_FC_DATA, d, {16'h0, ~d[7:0], 8'h05}, 0);
        chk(fc_data[39:8], {~d[7:0], d[31:8]}, "five bytes");
        cmdr(`CMD_FC_MODE, 2, 0, 0);
        chk(fc_mode, 2'h2, "mode data");
        cmdr(`CMD_FC_MODE, 1, 0, 1);
        cmdr(`CMD_FC_HDR, d, 0, 0);
        chk({fc_header_long, fc_header}, d & 32'h7ff, "short id");
        cmdr(`CMD_FC_HDR, ~d, 32'h100, 0);
        chk({fc_header_long, fc_header}, {1'b1, ~d[28:0]}, "long id");
        cmdr(`CMD_FC_MODE, 1, 0, 0);
        chk(fc_mode, 2'h1, "mode user");
        cmdr(`CMD_FC_MODE, 3, 0, 1);
        cmdr(`CMD_FC_MODE, 0, 0, 0);
        chk(fc_mode, 2'h0, "mode auto");
        cmdr(4'hf, 0, 0, 1);
        $display("test flow control done");
        wr(`OFS_PARAM, 32'h20);
        ev(1, 0);
        chk(can_search_blocked, 1, "fatal blocks");
        cmd(`CMD_FORGET, 0, 0);
        ev(0, 0);
        chk(can_search_blocked, 0, "forget clears");
        wr(`OFS_PARAM, 32'h11);
        ev(1, 0);
        chk(can_search_blocked, 0, "fatal not enabled");
        ev(0, 1);
        chk(can_search_blocked, 1, "low voltage blocks");
        cmd(`CMD_FORGET, 0, 0);
        ev(0, 0);
        chk(can_search_blocked, 0, "forget clears");
        @(posedge core_clk);
        stored_protocol <= 4'($urandom % 13);
        cmd(`CMD_DEFAULTS, 0, 0);
        chk({close_protocol, restore_defaults}, 2'h3, "defaults pulses");
        rd(`OFS_STATUS, v);
        chk(v[14:11], stored_protocol, "stored protocol");
        chk(length_digit_show, 1, "length default");
        $display("test events and defaults done");
        @(posedge core_clk);
        volt_sample <= 10'(200 + $urandom % 800);
        cmd(`CMD_CAL, 32'h1199, 0);
        wr(`OFS_CMD, {28'h0, `CMD_ECHO_OFF});
        rd(`OFS_STATUS, v);
        chk({v[15], v[2], v[0]}, 3'h7, "refused while busy");
        cal(16'h1199);
        chk(v, {15'h0, 1'b1, scale_of(volt_sample, 16'h1199)}, "user scale");
        chk(volt_reading, (volt_sample * v[15:0]) >> 12, "reading");
        cmdr(`CMD_CAL, 32'h12a4, 0, 1);
        cal(16'h0000);
        chk(v, {16'h0, fhi}, "factory high");
        @(posedge core_clk);
        supply_above_4v <= 1'b0;
        repeat (5) @(posedge core_clk);
        cal(16'h0000);
        chk(v, {16'h0, flo}, "factory low");
        $display("test calibration done");
        wrap_up;
    end
endmodule // obd_config_command_handler_bench

bind obd_config_command_handler obd_cfg_props props (.core_clk(core_clk), .arst_n(arst_n),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rx_valid(rx_valid), .echo_valid(echo_valid),
    .fatal_can_error_event(fatal_can_error_event),
    .low_voltage_reset_event(low_voltage_reset_event), .first_frame_rx(first_frame_rx),
    .flow_ctrl_send(flow_ctrl_send), .close_protocol(close_protocol),
    .fast_init_start(fast_init_start), .dm1_monitor(dm1_monitor),
    .can_search_blocked(can_search_blocked), .fc_mode(fc_mode), .fc_header(fc_header),
    .fc_header_long(fc_header_long));

`default_nettype wire
